// File: logic/rtgf_map.vh
/*
 * Register map, field positions, reset values and decode codes for the
 * receive/transmit gain and filter control block.
 * Assumes it is included by bare name and that every register is
 * fourteen bits wide, addressed by a four-bit register address.
 */
`ifndef RTGF_MAP_VH
`define RTGF_MAP_VH

// Register addresses
`define RTGF_ADDR_FILTER_TRIM   4'h7
`define RTGF_ADDR_BB_MODE       4'h8
`define RTGF_ADDR_TX_GAIN_SRC   4'h9
`define RTGF_ADDR_RX_GAIN       4'hB
`define RTGF_ADDR_TX_GAIN       4'hC
`define RTGF_ADDR_OUT_BIAS      4'hF

// Register reset values
`define RTGF_RST_REG            14'h0000

// filter_trim_config fields
`define RTGF_RX_FINE            2:0
`define RTGF_TX_FINE            5:3
`define RTGF_NEAR_DC            13:12
`define RTGF_NEAR_DC_LSB        12

// baseband_mode_config fields
`define RTGF_LPF_COARSE         1:0
`define RTGF_IND_SEL            9:8
`define RTGF_IND_GATE           10
`define RTGF_RX_SERIAL          12

// tx_gain_source_config field
`define RTGF_TX_SERIAL          10

// rx_gain_setting / tx_gain_setting fields
`define RTGF_LNA_CODE           6:5
`define RTGF_RX_VGA_CODE        4:0
`define RTGF_TX_VGA_CODE        5:0

// output_bias_config field
`define RTGF_VCM_SEL            11:10

// Indicator multiplexer codes
`define RTGF_IND_SIGNAL_STRENGTH_OUTPUT           2'h0
`define RTGF_IND_TEMP           2'h1
`define RTGF_IND_PDET           2'h2

// Near-DC corner codes
`define RTGF_NDC_100HZ          2'h0
`define RTGF_NDC_30KHZ          2'h2

// Gain code limits and fine-trim span
`define RTGF_RX_VGA_MAX         5'h1F
`define RTGF_TX_VGA_MAX         6'h3F
`define RTGF_TX_HALF_STEP_MIN   6'h30
`define RTGF_TX_COARSE_TOP      6'h2F
`define RTGF_TX_COARSE_BASE     6'h10
`define RTGF_RX_FINE_LAST       3'h4
`define RTGF_TX_FINE_LAST       3'h5

`endif

// File: logic/rtgf_control.v
/*
 * Digital control decode for the receive and transmit chains: gain
 * source selection, LNA and VGA gain decode, lowpass and highpass corner
 * decode, indicator multiplexer gating and receive/transmit enables.
 * Six fourteen-bit control registers are held here; together with the
 * control and gain pins they are turned into coded or one-hot settings
 * for the analog receive and transmit chains.
 * Reset clears every register to zero, which selects pin gain control,
 * the 100Hz near-DC corner and the signal strength indicator source.
 *
 * Assumes register writes arrive as completed words from the serial port
 * logic (one-cycle strobe with address and data), and that all pins are
 * synchronous to REF_CLK_I.
 * Assumes the register address also selects the readback word, so the
 * addressed register shows on readback one clock later.
 * Assumes the analog side tolerates the one-clock lag of every decoded
 * output behind its pin or register source; in return no output can
 * glitch, since each one comes straight from a flip-flop.
 * Assumes the controller keeps the shared gain pins at the code of the
 * chain in use, since receive and transmit gain read the same pins.
 */
//
// Summary of operation
// - LNA code 11 high, 10 medium (-16dB), 0X low (-33dB).
// - LNA code from rx gain register when serial select set, else pins.
// - Rx VGA code binary weighted, 2dB per LSB, 62dB span.
// - Rx VGA code from rx gain register when serial select set, else pins.
// - Coarse lowpass code gives rx corner 7.5, 8.5, 15 or 18MHz.
// - Rx fine trim 90 to 110 percent in 5 percent steps.
// - Highpass select high forces 600kHz AC coupling.
// - Highpass select low: near-DC corner 100Hz, 4kHz or 30kHz.
// - Output bias field selects receive common-mode level 1.2V to 1.5V.
// - Indicator source: signal strength (receive only), temperature, power.
// - Gate bit set makes indicator active only with highpass select high.
// - Transmit enabled by select and shutdown release high; uses port two.
// - Same coarse code gives tx corner 8, 11, 16.5 or 22.5MHz.
// - Tx fine trim 90 to 115 percent; codes 110 and 111 unused.
// - Tx VGA six-bit code, 0.5dB steps on top 8dB, 1dB below.
// - Tx gain source bit: zero selects pins, one selects register.
// - Receiver enabled by select low and shutdown release high.
`timescale 1ns/1ps
`include "rtgf_map.vh"

module rtgf_control (
   // Clock and reset
   input  wire        REF_CLK_I,
   input  wire        RST_I,
   // Completed register write from the serial port
   input  wire        REG_WR_I,
   input  wire [3:0]  REG_ADDR_I,
   input  wire [13:0] REG_DATA_I,
   // Control pins
   input  wire        RX_TX_SELECT_I,
   input  wire        SHUTDOWN_RELEASE_I,
   input  wire        HIGHPASS_SELECT_I,
   input  wire        ANTENNA_SELECT_I,
   input  wire [7:1]  GAIN_PINS_I,
   // Register readback of the addressed word
   output reg  [13:0] REG_RD_DATA_O,
   // Receive gain decode
   output reg  [1:0]  LNA_GAIN_O,
   output reg  [2:0]  LNA_MODE_O,
   output reg  [4:0]  RX_VGA_GAIN_O,
   output reg  [5:0]  RX_VGA_ATTEN_DB_O,
   // Transmit gain decode
   output reg  [5:0]  TX_VGA_GAIN_O,
   output reg  [5:0]  TX_VGA_ATTEN_HALF_DB_O,
   // Filter decode
   output reg  [3:0]  LPF_COARSE_O,
   output reg  [4:0]  RX_LPF_FINE_O,
   output reg  [5:0]  TX_LPF_FINE_O,
   output reg  [3:0]  HPF_CORNER_O,
   output reg  [1:0]  VCM_SEL_O,
   // Indicator multiplexer
   output reg  [2:0]  IND_SOURCE_O,
   output reg         IND_ACTIVE_O,
   // Mode enables and antenna routing
   output reg         RX_EN_O,
   output reg         TX_EN_O,
   output reg         SECOND_ANTENNA_PORT_O
);

   // Register file, one word per documented register
   reg [13:0] filter_trim_config;
   reg [13:0] baseband_mode_config;
   reg [13:0] tx_gain_source_config;
   reg [13:0] rx_gain_setting;
   reg [13:0] tx_gain_setting;
   reg [13:0] output_bias_config;

   // Shared gain pins, sliced per use
   wire [1:0] lna_gain_pins    = GAIN_PINS_I[7:6];
   wire [4:0] rx_vga_gain_pins = GAIN_PINS_I[5:1];
   wire [5:0] tx_vga_gain_pins = GAIN_PINS_I[6:1];

   // Next values of the decoded outputs
   reg  [13:0] next_rd_data;
   reg  [1:0]  next_lna;
   reg  [2:0]  next_lna_mode;
   reg  [4:0]  next_rx_vga;
   reg  [5:0]  next_rx_atten;
   reg  [5:0]  next_tx_vga;
   reg  [5:0]  next_tx_atten;
   reg  [5:0]  tx_below;
   reg  [3:0]  next_hpf;
   reg  [3:0]  next_coarse;
   reg  [4:0]  next_rx_fine;
   reg  [5:0]  next_tx_fine;
   reg  [2:0]  next_ind_src;
   reg         next_ind_act;
   reg         src_on;
   reg  [1:0]  ind_sel;
   reg         rx_mode;
   reg         tx_mode;

   // Register writes; values hold until rewritten, so settings persist
   // Unknown addresses fall through, so stray writes change nothing
   always @(posedge REF_CLK_I) begin
      if (RST_I) begin
         filter_trim_config    <= `RTGF_RST_REG;
         baseband_mode_config  <= `RTGF_RST_REG;
         tx_gain_source_config <= `RTGF_RST_REG;
         rx_gain_setting       <= `RTGF_RST_REG;
         tx_gain_setting       <= `RTGF_RST_REG;
         output_bias_config    <= `RTGF_RST_REG;
      end else if (REG_WR_I) begin
         if (REG_ADDR_I == `RTGF_ADDR_FILTER_TRIM) begin
            filter_trim_config <= REG_DATA_I;
         end else if (REG_ADDR_I == `RTGF_ADDR_BB_MODE) begin
            baseband_mode_config <= REG_DATA_I;
         end else if (REG_ADDR_I == `RTGF_ADDR_TX_GAIN_SRC) begin
            tx_gain_source_config <= REG_DATA_I;
         end else if (REG_ADDR_I == `RTGF_ADDR_RX_GAIN) begin
            rx_gain_setting <= REG_DATA_I;
         end else if (REG_ADDR_I == `RTGF_ADDR_TX_GAIN) begin
            tx_gain_setting <= REG_DATA_I;
         end else if (REG_ADDR_I == `RTGF_ADDR_OUT_BIAS) begin
            output_bias_config <= REG_DATA_I;
         end
      end
   end

   // Readback mux; addresses outside this block read as zero
   // Read is registered like every output, so it trails the address
   always @* begin
      if (REG_ADDR_I == `RTGF_ADDR_FILTER_TRIM) begin
         next_rd_data = filter_trim_config;
      end else if (REG_ADDR_I == `RTGF_ADDR_BB_MODE) begin
         next_rd_data = baseband_mode_config;
      end else if (REG_ADDR_I == `RTGF_ADDR_TX_GAIN_SRC) begin
         next_rd_data = tx_gain_source_config;
      end else if (REG_ADDR_I == `RTGF_ADDR_RX_GAIN) begin
         next_rd_data = rx_gain_setting;
      end else if (REG_ADDR_I == `RTGF_ADDR_TX_GAIN) begin
         next_rd_data = tx_gain_setting;
      end else if (REG_ADDR_I == `RTGF_ADDR_OUT_BIAS) begin
         next_rd_data = output_bias_config;
      end else begin
         next_rd_data = `RTGF_RST_REG;
      end
   end

   // Receive gain source and decode
   // Pin and register sources switch at once, with no hold-off
   always @* begin
      if (baseband_mode_config[`RTGF_RX_SERIAL]) begin
         next_lna    = rx_gain_setting[`RTGF_LNA_CODE];
         next_rx_vga = rx_gain_setting[`RTGF_RX_VGA_CODE];
      end else begin
         next_lna    = lna_gain_pins;
         next_rx_vga = rx_vga_gain_pins;
      end
      // 2dB per code step below the all-ones maximum
      next_rx_atten = {`RTGF_RX_VGA_MAX - next_rx_vga, 1'b0};
      // One-hot: bit2 high, bit1 medium, bit0 low; upper bit 0 is low
      if (!next_lna[1]) begin
         next_lna_mode = 3'h1;
      end else if (next_lna[0]) begin
         next_lna_mode = 3'h4;
      end else begin
         next_lna_mode = 3'h2;
      end
   end

   // Transmit gain source and attenuation in half-dB below maximum
   always @* begin
      if (tx_gain_source_config[`RTGF_TX_SERIAL]) begin
         next_tx_vga = tx_gain_setting[`RTGF_TX_VGA_CODE];
      end else begin
         next_tx_vga = tx_vga_gain_pins;
      end
      // Distance below the top code of the whole-dB region
      tx_below = `RTGF_TX_COARSE_TOP - next_tx_vga;
      // Lower codes pair up into whole-dB steps below the top 8dB
      if (next_tx_vga >= `RTGF_TX_HALF_STEP_MIN) begin
         next_tx_atten = `RTGF_TX_VGA_MAX - next_tx_vga;
      end else begin
         next_tx_atten = `RTGF_TX_COARSE_BASE
                       + {tx_below[5:1], 1'b0};
      end
   end

   // Highpass corner: bit3 600kHz, bit2 30kHz, bit1 4kHz, bit0 100Hz
   always @* begin
      if (HIGHPASS_SELECT_I) begin
         next_hpf = 4'h8;
      end else if (filter_trim_config[`RTGF_NEAR_DC_LSB]) begin
         next_hpf = 4'h2;
      end else if (filter_trim_config[`RTGF_NEAR_DC] ==
                   `RTGF_NDC_30KHZ) begin
         next_hpf = 4'h4;
      end else begin
         next_hpf = 4'h1;
      end
   end

   // Indicator multiplexer; the unlisted code 11 shows no signal
   // Strength gating looks at the select pin only, not shutdown release
   always @* begin
      rx_mode = SHUTDOWN_RELEASE_I & ~RX_TX_SELECT_I;
      tx_mode = SHUTDOWN_RELEASE_I & RX_TX_SELECT_I;
      ind_sel = baseband_mode_config[`RTGF_IND_SEL];
      if (ind_sel == `RTGF_IND_SIGNAL_STRENGTH_OUTPUT) begin
         next_ind_src = 3'h1;
         src_on       = ~RX_TX_SELECT_I;
      end else if (ind_sel == `RTGF_IND_TEMP) begin
         next_ind_src = 3'h2;
         src_on       = 1'b1;
      end else if (ind_sel == `RTGF_IND_PDET) begin
         next_ind_src = 3'h4;
         src_on       = 1'b1;
      end else begin
         next_ind_src = 3'h0;
         src_on       = 1'b0;
      end
      next_ind_act = src_on &
         (~baseband_mode_config[`RTGF_IND_GATE] |
          HIGHPASS_SELECT_I);
   end

   // Filter corner decode; fine codes past the last step select nothing
   always @* begin
      next_coarse = 4'h1 << baseband_mode_config[`RTGF_LPF_COARSE];
      if (filter_trim_config[`RTGF_RX_FINE] <= `RTGF_RX_FINE_LAST) begin
         next_rx_fine = 5'h01 << filter_trim_config[`RTGF_RX_FINE];
      end else begin
         next_rx_fine = 5'h00;
      end
      if (filter_trim_config[`RTGF_TX_FINE] <= `RTGF_TX_FINE_LAST) begin
         next_tx_fine = 6'h01 << filter_trim_config[`RTGF_TX_FINE];
      end else begin
         next_tx_fine = 6'h00;
      end
   end

   // All outputs registered; decode lags the source by one clock
   always @(posedge REF_CLK_I) begin
      if (RST_I) begin
         REG_RD_DATA_O          <= `RTGF_RST_REG;
         LNA_GAIN_O             <= 2'h0;
         LNA_MODE_O             <= 3'h0;
         RX_VGA_GAIN_O          <= 5'h00;
         RX_VGA_ATTEN_DB_O      <= 6'h00;
         TX_VGA_GAIN_O          <= 6'h00;
         TX_VGA_ATTEN_HALF_DB_O <= 6'h00;
         LPF_COARSE_O           <= 4'h0;
         RX_LPF_FINE_O          <= 5'h00;
         TX_LPF_FINE_O          <= 6'h00;
         HPF_CORNER_O           <= 4'h0;
         VCM_SEL_O              <= 2'h0;
         IND_SOURCE_O           <= 3'h0;
         IND_ACTIVE_O           <= 1'b0;
         RX_EN_O                <= 1'b0;
         TX_EN_O                <= 1'b0;
         SECOND_ANTENNA_PORT_O  <= 1'b0;
      end else begin
         REG_RD_DATA_O     <= next_rd_data;
         LNA_GAIN_O        <= next_lna;
         LNA_MODE_O        <= next_lna_mode;
         RX_VGA_GAIN_O     <= next_rx_vga;
         RX_VGA_ATTEN_DB_O <= next_rx_atten;
         TX_VGA_GAIN_O          <= next_tx_vga;
         TX_VGA_ATTEN_HALF_DB_O <= next_tx_atten;
         // One coarse code drives both rx and tx corners
         LPF_COARSE_O  <= next_coarse;
         RX_LPF_FINE_O <= next_rx_fine;
         TX_LPF_FINE_O <= next_tx_fine;
         HPF_CORNER_O <= next_hpf;
         VCM_SEL_O    <= output_bias_config[`RTGF_VCM_SEL];
         IND_SOURCE_O <= next_ind_src;
         IND_ACTIVE_O <= next_ind_act;
         // Enables lag the pins by one clock; no settling is modelled
         RX_EN_O      <= rx_mode;
         TX_EN_O      <= tx_mode;
         // Transmit always uses port two; receive follows the pin
         SECOND_ANTENNA_PORT_O <= RX_TX_SELECT_I |
                                  ANTENNA_SELECT_I;
      end
   end

endmodule // rtgf_control

// File: testbench/rtgf_control_monitor.sv
/* Port checker for the gain and filter control block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module rtgf_control_monitor (
   // Clock, reset and write port
   input wire        REF_CLK_I,
   input wire        RST_I,
   input wire        REG_WR_I,
   input wire [3:0]  REG_ADDR_I,
   input wire [13:0] REG_DATA_I,
   // Control pins
   input wire        RX_TX_SELECT_I,
   input wire        SHUTDOWN_RELEASE_I,
   input wire        HIGHPASS_SELECT_I,
   input wire [7:1]  GAIN_PINS_I,
   // Watched outputs
   input wire [1:0]  LNA_GAIN_O,
   input wire [4:0]  RX_VGA_GAIN_O,
   input wire [5:0]  RX_VGA_ATTEN_DB_O,
   input wire [3:0]  HPF_CORNER_O,
   input wire        IND_ACTIVE_O,
   input wire        RX_EN_O,
   input wire        TX_EN_O,
   input wire        SECOND_ANTENNA_PORT_O
);
   reg [1:0] up;
   reg       rx_ser;
   reg       ind_gate;
   reg [1:0] lna_reg;
   reg [4:0] vga_reg;
   // Shadow of the source selects; outputs lag them by one edge
   always @(posedge REF_CLK_I) begin
      if (RST_I) begin
         up       <= 2'h0;
         rx_ser   <= 1'b0;
         ind_gate <= 1'b0;
         lna_reg  <= 2'h0;
         vga_reg  <= 5'h00;
      end else begin
         if (up != 2'h3) up <= up + 2'h1;
         if (REG_WR_I && REG_ADDR_I == 4'h8) begin
            rx_ser   <= REG_DATA_I[12];
            ind_gate <= REG_DATA_I[10];
         end
         if (REG_WR_I && REG_ADDR_I == 4'hB) begin
            lna_reg <= REG_DATA_I[6:5];
            vga_reg <= REG_DATA_I[4:0];
         end
      end
   end
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   tx_enable_a: assert property (up == 2'h3 |-> TX_EN_O ==
      ($past(RX_TX_SELECT_I) && $past(SHUTDOWN_RELEASE_I)))
      else $error("transmit enable mismatch");
   rx_enable_a: assert property (up == 2'h3 |-> RX_EN_O ==
      (!$past(RX_TX_SELECT_I) && $past(SHUTDOWN_RELEASE_I)))
      else $error("receive enable mismatch");
   antenna_route_a: assert property (up == 2'h3 &&
      $past(RX_TX_SELECT_I) |-> SECOND_ANTENNA_PORT_O)
      else $error("transmit not on port two");
   ac_coupling_a: assert property (up == 2'h3 &&
      $past(HIGHPASS_SELECT_I) |-> HPF_CORNER_O == 4'h8)
      else $error("highpass corner not forced");
   lna_source_a: assert property (up == 2'h3 |-> LNA_GAIN_O ==
      ($past(rx_ser) ? $past(lna_reg) : $past(GAIN_PINS_I[7:6])))
      else $error("lna code source wrong");
   vga_source_a: assert property (up == 2'h3 |-> RX_VGA_GAIN_O ==
      ($past(rx_ser) ? $past(vga_reg) : $past(GAIN_PINS_I[5:1])))
      else $error("rx vga code source wrong");
   rx_atten_a: assert property (up == 2'h3 |->
      RX_VGA_ATTEN_DB_O == 6'h3E - {RX_VGA_GAIN_O, 1'b0})
      else $error("rx vga step wrong");
   ind_gate_a: assert property (up == 2'h3 && $past(ind_gate) &&
      !$past(HIGHPASS_SELECT_I) |-> !IND_ACTIVE_O)
      else $error("indicator not gated");
endmodule // rtgf_control_monitor
bind rtgf_control rtgf_control_monitor u_mon (.REF_CLK_I(REF_CLK_I),
   .RST_I(RST_I), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_DATA_I(REG_DATA_I), .RX_TX_SELECT_I(RX_TX_SELECT_I),
   .SHUTDOWN_RELEASE_I(SHUTDOWN_RELEASE_I), .GAIN_PINS_I(GAIN_PINS_I),
   .HIGHPASS_SELECT_I(HIGHPASS_SELECT_I), .LNA_GAIN_O(LNA_GAIN_O),
   .RX_VGA_GAIN_O(RX_VGA_GAIN_O), .RX_VGA_ATTEN_DB_O(RX_VGA_ATTEN_DB_O),
   .HPF_CORNER_O(HPF_CORNER_O), .IND_ACTIVE_O(IND_ACTIVE_O),
   .RX_EN_O(RX_EN_O), .TX_EN_O(TX_EN_O),
   .SECOND_ANTENNA_PORT_O(SECOND_ANTENNA_PORT_O));

// File: testbench/rtgf_bb_model.sv
/* Baseband controller model: control pins and completed register writes.
   Assumes a free-running clock; everything changes at falling edges. */
`timescale 1ns/1ps
module rtgf_bb_model (
   // Clock
   input  wire        clk_i,
   // Register write port
   output reg         wr_o,
   output reg  [3:0]  addr_o,
   output reg  [13:0] data_o,
   // Pins: rx_tx_select, shutdown_release, highpass_select, antenna_select
   output reg  [3:0]  ctl_o,
   output reg  [7:1]  gain_o
);
   initial begin
      wr_o = 1'b0;
      addr_o = 4'h0;
      data_o = 14'h0000;
      ctl_o = 4'h0;
      gain_o = 7'h00;
   end
   // One-cycle strobe; idle data shows the inverse so stale values fail
   task put(input [3:0] a, input [13:0] d);
      begin
         @(negedge clk_i);
         wr_o = 1'b1;
         addr_o = a;
         data_o = d;
         @(negedge clk_i);
         wr_o = 1'b0;
         data_o = ~d;
         @(negedge clk_i);
      end
   endtask
   // Shared gain pins carry rx or tx codes
   task pins(input [3:0] c, input [7:1] g);
      begin
         @(negedge clk_i);
         ctl_o = c;
         gain_o = g;
         @(negedge clk_i);
      end
   endtask
   // Readback address, answer one edge later
   task look(input [3:0] a);
      begin
         @(negedge clk_i);
         addr_o = a;
         @(negedge clk_i);
      end
   endtask
endmodule // rtgf_bb_model

// File: testbench/test_rtgf_control.sv
/* Self-checking bench for the gain and filter control block.
   Assumes the baseband model and the bound port checker. */
`timescale 1ns/1ps
module test_rtgf_control;
   reg         clk;
   reg         rst;
   wire        wr;
   wire [3:0]  addr;
   wire [3:0]  ctl;
   wire [3:0]  coarse;
   wire [3:0]  hpf;
   wire [13:0] wdata;
   wire [13:0] rdata;
   wire [7:1]  gain;
   wire [1:0]  lna;
   wire [1:0]  vcm;
   wire [2:0]  lmode;
   wire [2:0]  isrc;
   wire [4:0]  vga;
   wire [4:0]  rxf;
   wire [5:0]  vatt;
   wire [5:0]  txg;
   wire [5:0]  txa;
   wire [5:0]  txf;
   wire        iact;
   wire        rxen;
   wire        txen;
   wire        second_antenna_port;
   integer     n_fail;
   integer     check_count;
   integer     i;
   rtgf_bb_model u_bb (.clk_i(clk), .wr_o(wr), .addr_o(addr),
      .data_o(wdata), .ctl_o(ctl), .gain_o(gain));
   rtgf_control u_dut (.REF_CLK_I(clk), .RST_I(rst), .REG_WR_I(wr),
      .REG_ADDR_I(addr), .REG_DATA_I(wdata), .RX_TX_SELECT_I(ctl[3]),
      .SHUTDOWN_RELEASE_I(ctl[2]), .HIGHPASS_SELECT_I(ctl[1]),
      .ANTENNA_SELECT_I(ctl[0]), .GAIN_PINS_I(gain), .REG_RD_DATA_O(rdata),
      .LNA_GAIN_O(lna), .LNA_MODE_O(lmode), .RX_VGA_GAIN_O(vga),
      .RX_VGA_ATTEN_DB_O(vatt), .TX_VGA_GAIN_O(txg),
      .TX_VGA_ATTEN_HALF_DB_O(txa), .LPF_COARSE_O(coarse),
      .RX_LPF_FINE_O(rxf), .TX_LPF_FINE_O(txf), .HPF_CORNER_O(hpf),
      .VCM_SEL_O(vcm), .IND_SOURCE_O(isrc), .IND_ACTIVE_O(iact),
      .RX_EN_O(rxen), .TX_EN_O(txen), .SECOND_ANTENNA_PORT_O(second_antenna_port));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Half-dB attenuation: fine steps on top, paired codes below
   function integer txatt(input integer c);
      txatt = (c >= 48) ? 63 - c : 16 + 2 * ((47 - c) / 2);
   endfunction
   task chk(input [13:0] got, input [13:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      n_fail = 0;
      check_count = 0;
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      // Every address reads zero after reset, unmapped ones included
      for (i = 0; i < 16; i = i + 1) begin
         u_bb.look(i[3:0]);
         chk(rdata, 14'h0000);
      end
      for (i = 0; i < 4; i = i + 1) begin
         u_bb.pins(4'h4, {i[1:0], 5'h00});
         chk(lmode, i[1] ? (i[0] ? 3'h4 : 3'h2) : 3'h1);
         chk(lna, i[1:0]);
      end
      for (i = 0; i < 32; i = i + 1) begin
         u_bb.pins(4'h4, {2'h3, i[4:0]});
         chk(vga, i[4:0]);
         chk(vatt, 62 - 2 * i);
      end
      // Serial gain source overrides the pins; stray write is dropped
      u_bb.put(4'h8, 14'h1000);
      u_bb.put(4'hB, 14'h004A);
      chk(rdata, 14'h004A);
      u_bb.put(4'hA, 14'h3FFF);
      u_bb.look(4'hB);
      chk(rdata, 14'h004A);
      chk(lmode, 3'h2);
      chk(vga, 5'h0A);
      for (i = 0; i < 4; i = i + 1) begin
         u_bb.put(4'h8, 14'h1000 | i);
         chk(coarse, 1 << i);
      end
      for (i = 0; i < 8; i = i + 1) begin
         u_bb.put(4'h7, {8'h00, i[2:0], i[2:0]});
         chk(rxf, (i < 5) ? 1 << i : 0);
         chk(txf, (i < 6) ? 1 << i : 0);
      end
      for (i = 0; i < 4; i = i + 1) begin
         u_bb.put(4'h7, {i[1:0], 12'h000});
         u_bb.pins(4'h4, 7'h00);
         chk(hpf, i[0] ? 4'h2 : (i[1] ? 4'h4 : 4'h1));
         u_bb.pins(4'h6, 7'h00);
         chk(hpf, 4'h8);
      end
      for (i = 0; i < 4; i = i + 1) begin
         u_bb.put(4'hF, i << 10);
         chk(vcm, i[1:0]);
      end
      // Indicator source and gating over all select, gate, highpass and rx/tx select pin states
      for (i = 0; i < 32; i = i + 1) begin
         u_bb.put(4'h8, {3'h0, i[2], i[1:0], 8'h00});
         u_bb.pins({i[4], 1'b1, i[3], 1'b0}, 7'h00);
         chk(isrc, (i[1:0] == 2'h3) ? 0 : 1 << i[1:0]);
         chk(iact, ((i[1:0] == 2'h0) ? !i[4] : (i[1:0] != 2'h3))
            && (!i[2] || i[3]));
      end
      for (i = 0; i < 8; i = i + 1) begin
         u_bb.pins({i[2], i[1], 1'b0, i[0]}, 7'h00);
         chk(rxen, i[1] && !i[2]);
         chk(txen, i[1] && i[2]);
         chk(second_antenna_port, i[2] || i[0]);
      end
      u_bb.put(4'h9, 14'h0000);
      for (i = 0; i < 64; i = i + 1) begin
         u_bb.pins(4'hC, {1'b0, i[5:0]});
         chk(txg, i[5:0]);
         chk(txa, txatt(i));
      end
      u_bb.put(4'h9, 14'h0400);
      u_bb.put(4'hC, 14'h0025);
      chk(txg, 6'h25);
      chk(txa, txatt(37));
      // A second reset clears the registers again
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      u_bb.look(4'hC);
      chk(rdata, 14'h0000);
      test_done;
   end
endmodule // test_rtgf_control
